// [logic/agd_pkg.sv]
package agd_pkg;
  localparam int CODE_W = 6;
  localparam int DLY_W = 8;
  localparam int CNT_W = 4;
  // 64 monotonically rising current steps: 0.5 mA up to 100 mA
  localparam logic [5:0] CODE_LOWEST = 6'h00;
  localparam logic [5:0] CODE_HIGHEST = 6'h3f;
  localparam logic [5:0] STEP_SMALL = 6'h01;
  localparam logic [5:0] STEP_LARGE = 6'h02;
  localparam logic [3:0] CNT_REG_THRESHOLD = 4'h8;
  localparam logic [3:0] CNT_SAT = 4'hf;
  localparam logic [1:0] FLIPS_NEEDED = 2'h3;
  localparam logic [7:0] DLY_SAT = 8'hff;
  localparam logic [1:0] MODE_NO_PRE = 2'h0;
  localparam logic [1:0] MODE_FIXED_PRE = 2'h1;
  // timing: system clock period and bridge driver clock period
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BD_PERIOD_PS = 50000;
  localparam int BD_DIV = (BD_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] BD_DIV_LAST = 4'(BD_DIV - 1);
endpackage

// [logic/agd_reg_tracker.sv]
`timescale 1ns/1ps
module agd_reg_tracker
  import agd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic adaptive_i,
  input wire logic update_i,
  input wire logic [agd_pkg::DLY_W-1:0] ton_meas_i,
  input wire logic [agd_pkg::DLY_W-1:0] ton_target_i,
  input wire logic [agd_pkg::DLY_W-1:0] toff_meas_i,
  input wire logic [agd_pkg::DLY_W-1:0] toff_target_i,
  output logic regulated_o
);
  import agd_pkg::*;

  logic [CNT_W-1:0] on_cnt_reg;
  logic [CNT_W-1:0] off_cnt_reg;
  logic [1:0] flips_reg;
  logic on_long_reg;
  logic off_long_reg;
  logic have_sign_reg;

  wire on_match = ton_meas_i == ton_target_i;
  wire off_match = toff_meas_i == toff_target_i;
  wire on_long = ton_meas_i > ton_target_i;
  wire off_long = toff_meas_i > toff_target_i;
  wire both_flip = have_sign_reg && !on_match && !off_match &&
                   (on_long != on_long_reg) && (off_long != off_long_reg);

  function automatic logic [CNT_W-1:0] sat_step(input logic [CNT_W-1:0] c, input logic up);
    if (up) begin
      sat_step = (c == CNT_SAT) ? c : c + 4'h1;
    end else begin
      sat_step = (c == 4'h0) ? c : c - 4'h1;
    end
  endfunction

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      on_cnt_reg <= 4'h0;
      off_cnt_reg <= 4'h0;
      flips_reg <= 2'h0;
      on_long_reg <= 1'b0;
      off_long_reg <= 1'b0;
      have_sign_reg <= 1'b0;
    end else if (clear_i || !adaptive_i) begin
      on_cnt_reg <= 4'h0;
      off_cnt_reg <= 4'h0;
      flips_reg <= 2'h0;
      have_sign_reg <= 1'b0;
    end else if (update_i) begin
      on_cnt_reg <= sat_step(on_cnt_reg, on_match);
      off_cnt_reg <= sat_step(off_cnt_reg, off_match);
      flips_reg <= both_flip ? ((flips_reg == FLIPS_NEEDED) ? flips_reg : flips_reg + 2'h1)
                             : 2'h0;
      on_long_reg <= on_long;
      off_long_reg <= off_long;
      have_sign_reg <= !on_match && !off_match;
    end
  end

  assign regulated_o = adaptive_i && (((on_cnt_reg >= CNT_REG_THRESHOLD) &&
                       (off_cnt_reg >= CNT_REG_THRESHOLD)) || (flips_reg == FLIPS_NEEDED));

  a_on_cnt_up: assert property (@(posedge clk_i) disable iff (rst_i)
    update_i && adaptive_i && !clear_i && on_match && on_cnt_reg != CNT_SAT
    |=> on_cnt_reg == $past(on_cnt_reg) + 4'h1)
    else $error("turn-on counter did not count up");
  a_off_cnt_down: assert property (@(posedge clk_i) disable iff (rst_i)
    update_i && adaptive_i && !clear_i && !off_match && off_cnt_reg != 4'h0
    |=> off_cnt_reg == $past(off_cnt_reg) - 4'h1)
    else $error("turn-off counter did not count down");
  a_reg_threshold: assert property (@(posedge clk_i) disable iff (rst_i)
    adaptive_i && on_cnt_reg >= CNT_REG_THRESHOLD && off_cnt_reg >= CNT_REG_THRESHOLD
    |-> regulated_o)
    else $error("flag missing with both counters at threshold");
  a_cnt_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_i |=> on_cnt_reg == 4'h0 && off_cnt_reg == 4'h0 && flips_reg == 2'h0)
    else $error("counters not cleared");
endmodule

// [logic/agd_sequencer.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - passive free-wheeling keeps the complementary gate off always.
// - passive rising edge skips cross-current wait, goes pre-charge, charge, post-charge.
// - passive falling edge skips cross-current wait, then pre-discharge and discharge.
// - low-side mapping swaps gate roles and switch-node thresholds.
// - one regulation flag, valid only in adaptive modes 10 and 11.
// - per cycle, delay counters count up on match, down otherwise.
// - regulated when both delay counters reach at least 8.
// - regulated when both delay errors flip sign three times in a row.
// - without time modulation, one constant current per pre-phase.
// - with time modulation, each pre-phase splits into two sub-intervals.
// - modes 00 and 01 stop adapting the pre-phase currents.
// - measured delays are reported in every mode.
// - mode 00 drops pre-charge and pre-discharge phases.
// - mode 01 pre-charges with the initial pre-charge setting.
// - mode 01 pre-discharges with the initial pre-discharge setting.
// - gate currents use a 6-bit code, 64 rising steps.
// - post-charge raises the code one step per bridge clock up to maximum.
// - adaptation moves one step or two steps per the step-size bit.
// - enabling PWM loads adapted current with min of initial and maximum.
module agd_sequencer
  import agd_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic PWM_I,
  input wire logic SW_NODE_HIGH_I,
  input wire logic SW_NODE_LOW_I,
  input wire logic PWM_ENABLE_I,
  input wire logic ACTIVE_FREEWHEEL_SELECT_I,
  input wire logic LOW_SIDE_MAP_I,
  input wire logic [1:0] GATE_CONTROL_MODE_I,
  input wire logic TIME_MODULATION_ENABLE_I,
  input wire logic ADAPT_STEP_SIZE_I,
  input wire logic [agd_pkg::CODE_W-1:0] INITIAL_PRECHARGE_CURRENT_I,
  input wire logic [agd_pkg::CODE_W-1:0] INITIAL_PREDISCHARGE_CURRENT_I,
  input wire logic [agd_pkg::CODE_W-1:0] MAX_GATE_CURRENT_I,
  input wire logic [agd_pkg::CODE_W-1:0] CHARGE_CURRENT_CODE_I,
  input wire logic [agd_pkg::CODE_W-1:0] DISCHARGE_CURRENT_CODE_I,
  input wire logic [agd_pkg::CODE_W-1:0] FREEWHEEL_CURRENT_CODE_I,
  input wire logic [agd_pkg::DLY_W-1:0] TARGET_TURN_ON_DELAY_I,
  input wire logic [agd_pkg::DLY_W-1:0] TARGET_TURN_OFF_DELAY_I,
  input wire logic [agd_pkg::DLY_W-1:0] PRECHARGE_DURATION_I,
  input wire logic [agd_pkg::DLY_W-1:0] PREDISCHARGE_DURATION_I,
  input wire logic [agd_pkg::DLY_W-1:0] CROSS_CURRENT_DURATION_I,
  output logic HS_SOURCE_O,
  output logic [agd_pkg::CODE_W-1:0] HS_CURRENT_CODE_O,
  output logic LS_SOURCE_O,
  output logic [agd_pkg::CODE_W-1:0] LS_CURRENT_CODE_O,
  output logic [agd_pkg::DLY_W-1:0] MEASURED_TURN_ON_O,
  output logic [agd_pkg::DLY_W-1:0] MEASURED_TURN_OFF_O,
  output logic DELAY_REGULATED_FLAG_O
);
  import agd_pkg::*;

  typedef enum logic [9:0] {
    ST_OFF = 10'h001,
    ST_CCP = 10'h002,
    ST_PRE = 10'h004,
    ST_CHG = 10'h008,
    ST_POST = 10'h010,
    ST_ON = 10'h020,
    ST_SYM = 10'h040,
    ST_PDIS = 10'h080,
    ST_DIS = 10'h100,
    ST_FW = 10'h200
  } agd_state_e;

  agd_state_e state_reg;
  agd_state_e state_next;

  logic pwm_s1_reg;
  logic pwm_s2_reg;
  logic pwm_d_reg;
  logic swh_s1_reg;
  logic swh_s2_reg;
  logic swl_s1_reg;
  logic swl_s2_reg;
  logic en_d_reg;
  logic [3:0] div_reg;
  logic tick_reg;
  logic [DLY_W-1:0] phase_cnt_reg;
  logic [DLY_W-1:0] dly_cnt_reg;
  logic [DLY_W-1:0] ton_reg;
  logic [DLY_W-1:0] toff_reg;
  logic [CODE_W-1:0] pre_adapt_reg;
  logic [CODE_W-1:0] pdis_adapt_reg;
  logic [CODE_W-1:0] pwm_code_reg;
  logic [CODE_W-1:0] pwm_code_next;
  logic cycle_done_reg;

  function automatic logic phase_over(input logic [DLY_W-1:0] cnt, input logic [DLY_W-1:0] dur);
    phase_over = ({1'b0, cnt} + 9'h001) >= {1'b0, dur};
  endfunction

  // one or two steps up or down, clamped between the lowest code and the maximum
  function automatic logic [CODE_W-1:0] adapt(input logic [CODE_W-1:0] code,
                                              input logic up, input logic big,
                                              input logic [CODE_W-1:0] lim);
    logic [CODE_W:0] sum;
    logic [CODE_W-1:0] step;
    step = big ? STEP_LARGE : STEP_SMALL;
    sum = up ? ({1'b0, code} + {1'b0, step}) : ({1'b0, code} - {1'b0, step});
    if (!up && sum[CODE_W]) begin
      adapt = CODE_LOWEST;
    end else if (sum > {1'b0, lim}) begin
      adapt = lim;
    end else begin
      adapt = sum[CODE_W-1:0];
    end
  endfunction

  function automatic logic [CODE_W-1:0] min_code(input logic [CODE_W-1:0] a,
                                                 input logic [CODE_W-1:0] b);
    min_code = (a < b) ? a : b;
  endfunction

  // input synchronisers and bridge driver clock enable
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pwm_s1_reg <= 1'b0;
      pwm_s2_reg <= 1'b0;
      pwm_d_reg <= 1'b0;
      swh_s1_reg <= 1'b0;
      swh_s2_reg <= 1'b0;
      swl_s1_reg <= 1'b0;
      swl_s2_reg <= 1'b0;
      en_d_reg <= 1'b0;
      div_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      pwm_s1_reg <= PWM_I;
      pwm_s2_reg <= pwm_s1_reg;
      pwm_d_reg <= pwm_s2_reg;
      swh_s1_reg <= SW_NODE_HIGH_I;
      swh_s2_reg <= swh_s1_reg;
      swl_s1_reg <= SW_NODE_LOW_I;
      swl_s2_reg <= swl_s1_reg;
      en_d_reg <= PWM_ENABLE_I;
      div_reg <= (div_reg == BD_DIV_LAST) ? 4'h0 : div_reg + 4'h1;
      tick_reg <= div_reg == BD_DIV_LAST;
    end
  end

  wire afw = ACTIVE_FREEWHEEL_SELECT_I;
  wire adaptive = GATE_CONTROL_MODE_I[1];
  wire skip_pre = GATE_CONTROL_MODE_I == MODE_NO_PRE;
  wire fixed_pre = GATE_CONTROL_MODE_I == MODE_FIXED_PRE;
  wire en_rise = PWM_ENABLE_I && !en_d_reg;
  wire pwm_rise = pwm_s2_reg && !pwm_d_reg;
  wire pwm_fall = !pwm_s2_reg && pwm_d_reg;
  wire on_reached = LOW_SIDE_MAP_I ? swl_s2_reg : swh_s2_reg;
  wire off_reached = LOW_SIDE_MAP_I ? swh_s2_reg : swl_s2_reg;
  wire dly_sat = dly_cnt_reg == DLY_SAT;
  wire in_off = state_reg inside {ST_OFF, ST_SYM, ST_PDIS, ST_DIS, ST_FW};
  wire ccp_over = tick_reg && phase_over(phase_cnt_reg, CROSS_CURRENT_DURATION_I);
  wire first_on = skip_pre ? 1'b0 : 1'b1;
  wire second_half = TIME_MODULATION_ENABLE_I &&
                     ({phase_cnt_reg, 1'b0} >= {1'b0, PRECHARGE_DURATION_I});
  wire second_half_dis = TIME_MODULATION_ENABLE_I &&
                         ({phase_cnt_reg, 1'b0} >= {1'b0, PREDISCHARGE_DURATION_I});
  wire leave_chg = state_reg == ST_CHG && state_next != ST_CHG;
  wire leave_dis = state_reg == ST_DIS && state_next != ST_DIS;
  wire measuring = state_reg inside {ST_PRE, ST_CHG, ST_PDIS, ST_DIS};
  wire start_on = state_next inside {ST_PRE, ST_CHG} && !(state_reg inside {ST_PRE, ST_CHG});
  wire start_off = state_next inside {ST_PDIS, ST_DIS} &&
                   !(state_reg inside {ST_PDIS, ST_DIS});

  always_comb begin
    state_next = state_reg;
    if (!PWM_ENABLE_I) begin
      state_next = ST_OFF;
    end else if (pwm_rise && in_off) begin
      state_next = afw ? ST_CCP : (first_on ? ST_PRE : ST_CHG);
    end else if (pwm_fall && !in_off) begin
      state_next = afw ? ST_SYM : (skip_pre ? ST_DIS : ST_PDIS);
    end else begin
      case (state_reg)
        ST_CCP: begin
          if (ccp_over) begin
            state_next = skip_pre ? ST_CHG : ST_PRE;
          end
        end
        ST_PRE: begin
          if (tick_reg && phase_over(phase_cnt_reg, PRECHARGE_DURATION_I)) begin
            state_next = ST_CHG;
          end
        end
        ST_CHG: begin
          if (on_reached || dly_sat) begin
            state_next = ST_POST;
          end
        end
        ST_POST: begin
          if (pwm_code_reg >= MAX_GATE_CURRENT_I) begin
            state_next = ST_ON;
          end
        end
        ST_SYM: begin
          if (ccp_over) begin
            state_next = skip_pre ? ST_DIS : ST_PDIS;
          end
        end
        ST_PDIS: begin
          if (tick_reg && phase_over(phase_cnt_reg, PREDISCHARGE_DURATION_I)) begin
            state_next = ST_DIS;
          end
        end
        ST_DIS: begin
          if (off_reached || dly_sat) begin
            state_next = ST_FW;
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  // current code for the gate of the PWM MOSFET
  always_comb begin
    pwm_code_next = DISCHARGE_CURRENT_CODE_I;
    case (state_next)
      ST_PRE: begin
        if (fixed_pre || (second_half && state_reg == ST_PRE)) begin
          pwm_code_next = INITIAL_PRECHARGE_CURRENT_I;
        end else begin
          pwm_code_next = pre_adapt_reg;
        end
      end
      ST_PDIS: begin
        if (fixed_pre || (second_half_dis && state_reg == ST_PDIS)) begin
          pwm_code_next = INITIAL_PREDISCHARGE_CURRENT_I;
        end else begin
          pwm_code_next = pdis_adapt_reg;
        end
      end
      ST_CHG: begin
        pwm_code_next = CHARGE_CURRENT_CODE_I;
      end
      ST_POST, ST_ON: begin
        if (state_reg != ST_POST && state_reg != ST_ON) begin
          pwm_code_next = CHARGE_CURRENT_CODE_I;
        end else if (tick_reg && pwm_code_reg < MAX_GATE_CURRENT_I) begin
          pwm_code_next = pwm_code_reg + 6'h01;
        end else begin
          pwm_code_next = pwm_code_reg;
        end
      end
      ST_SYM: begin
        pwm_code_next = pwm_code_reg;
      end
      default: begin
        pwm_code_next = DISCHARGE_CURRENT_CODE_I;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_reg <= ST_OFF;
      phase_cnt_reg <= 8'h00;
      pwm_code_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      pwm_code_reg <= pwm_code_next;
      if (state_next != state_reg) begin
        phase_cnt_reg <= 8'h00;
      end else if (tick_reg && phase_cnt_reg != DLY_SAT) begin
        phase_cnt_reg <= phase_cnt_reg + 8'h01;
      end
    end
  end

  // delay measurement runs in every mode
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dly_cnt_reg <= 8'h00;
      ton_reg <= 8'h00;
      toff_reg <= 8'h00;
      cycle_done_reg <= 1'b0;
    end else begin
      cycle_done_reg <= leave_dis;
      if (start_on || start_off) begin
        dly_cnt_reg <= 8'h00;
      end else if (measuring && tick_reg && !dly_sat) begin
        dly_cnt_reg <= dly_cnt_reg + 8'h01;
      end
      if (leave_chg) begin
        ton_reg <= dly_cnt_reg;
      end
      if (leave_dis) begin
        toff_reg <= dly_cnt_reg;
      end
    end
  end

  // pre-phase current adaptation
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pre_adapt_reg <= 6'h00;
      pdis_adapt_reg <= 6'h00;
    end else if (en_rise) begin
      pre_adapt_reg <= min_code(INITIAL_PRECHARGE_CURRENT_I, MAX_GATE_CURRENT_I);
      pdis_adapt_reg <= min_code(INITIAL_PREDISCHARGE_CURRENT_I, MAX_GATE_CURRENT_I);
    end else if (adaptive) begin
      if (leave_chg && dly_cnt_reg != TARGET_TURN_ON_DELAY_I) begin
        pre_adapt_reg <= adapt(pre_adapt_reg, dly_cnt_reg > TARGET_TURN_ON_DELAY_I,
                               ADAPT_STEP_SIZE_I, MAX_GATE_CURRENT_I);
      end
      if (leave_dis && dly_cnt_reg != TARGET_TURN_OFF_DELAY_I) begin
        pdis_adapt_reg <= adapt(pdis_adapt_reg, dly_cnt_reg > TARGET_TURN_OFF_DELAY_I,
                                ADAPT_STEP_SIZE_I, MAX_GATE_CURRENT_I);
      end
    end
  end

  agd_reg_tracker u_tracker (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .clear_i(en_rise),
    .adaptive_i(adaptive),
    .update_i(cycle_done_reg),
    .ton_meas_i(ton_reg),
    .ton_target_i(TARGET_TURN_ON_DELAY_I),
    .toff_meas_i(toff_reg),
    .toff_target_i(TARGET_TURN_OFF_DELAY_I),
    .regulated_o(DELAY_REGULATED_FLAG_O)
  );

  // the pwm gate stays on through the symmetrization wait after a falling edge
  wire pwm_src = state_reg inside {ST_PRE, ST_CHG, ST_POST, ST_ON, ST_SYM};
  wire fw_src = afw && state_reg == ST_FW && off_reached;
  assign HS_SOURCE_O = LOW_SIDE_MAP_I ? fw_src : pwm_src;
  assign LS_SOURCE_O = LOW_SIDE_MAP_I ? pwm_src : fw_src;
  assign HS_CURRENT_CODE_O = (LOW_SIDE_MAP_I && afw) ? FREEWHEEL_CURRENT_CODE_I
                             : (LOW_SIDE_MAP_I ? DISCHARGE_CURRENT_CODE_I : pwm_code_reg);
  assign LS_CURRENT_CODE_O = (!LOW_SIDE_MAP_I && afw) ? FREEWHEEL_CURRENT_CODE_I
                             : (!LOW_SIDE_MAP_I ? DISCHARGE_CURRENT_CODE_I : pwm_code_reg);
  assign MEASURED_TURN_ON_O = ton_reg;
  assign MEASURED_TURN_OFF_O = toff_reg;

  sequence s_passive_fall;
    PWM_ENABLE_I && !afw && pwm_fall && !in_off && !skip_pre;
  endsequence
  sequence s_enter_pdis;
    state_reg == ST_PDIS ##1 state_reg inside {ST_PDIS, ST_DIS};
  endsequence

  a_passive_fw_off: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !afw |-> !(LOW_SIDE_MAP_I ? HS_SOURCE_O : LS_SOURCE_O))
    else $error("complementary gate sourced in passive mode");
  a_passive_rise: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    PWM_ENABLE_I && !afw && pwm_rise && in_off && !skip_pre |=> state_reg == ST_PRE)
    else $error("passive rise did not go straight to pre-charge");
  a_passive_fall: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    s_passive_fall |=> s_enter_pdis)
    else $error("passive fall did not go straight to pre-discharge");
  a_low_side_swap: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    LOW_SIDE_MAP_I |-> LS_SOURCE_O == pwm_src)
    else $error("low-side mapping not swapped");
  a_flag_mode: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !adaptive |-> !DELAY_REGULATED_FLAG_O)
    else $error("regulation flag outside adaptive mode");
  a_const_pre: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    state_reg == ST_PRE && $past(state_reg) == ST_PRE && !TIME_MODULATION_ENABLE_I
    && $stable(pre_adapt_reg) |-> $stable(pwm_code_reg))
    else $error("pre-charge current changed without time modulation");
  a_no_adapt: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !adaptive && !en_rise |=> $stable(pre_adapt_reg) && $stable(pdis_adapt_reg))
    else $error("adaptation in a non-adaptive mode");
  a_no_pre_phase: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    skip_pre && $past(skip_pre) |-> !(state_reg inside {ST_PRE, ST_PDIS}))
    else $error("pre-phase entered in mode 00");
  a_fixed_pre: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    state_reg != ST_PRE && state_next == ST_PRE && fixed_pre
    |=> pwm_code_reg == $past(INITIAL_PRECHARGE_CURRENT_I))
    else $error("mode 01 pre-charge not at initial setting");
  a_post_ramp: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    state_reg == ST_POST && state_next == ST_POST && tick_reg && !pwm_fall
    |=> pwm_code_reg == $past(pwm_code_reg) + 6'h01)
    else $error("post-charge did not step once per bridge clock");
  a_enable_init: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    en_rise |=> pre_adapt_reg == min_code($past(INITIAL_PRECHARGE_CURRENT_I),
                                           $past(MAX_GATE_CURRENT_I)))
    else $error("adapted pre-charge not initialised on enable");
endmodule

// [verification/agd_bridge_model.sv]
`timescale 1ns/1ps
// half-bridge switch node: follows the PWM gate after a fixed switching delay
module agd_bridge_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hs_src_i,
  input wire logic ls_src_i,
  input wire logic ls_map_i,
  output logic sw_high_o,
  output logic sw_low_o
);
  localparam int SW_DLY = 40;
  logic node_target;
  logic node_reg;
  int cnt;
  // high-side on pulls the node up, low-side on pulls it down
  assign node_target = ls_map_i ? ~ls_src_i : hs_src_i;
  assign sw_high_o = node_reg;
  assign sw_low_o = ~node_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      node_reg <= 1'b0;
    end else if (node_target == node_reg) begin
      cnt <= 0;
    end else if (cnt == SW_DLY) begin
      cnt <= 0;
      node_reg <= node_target;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [verification/agd_sequencer_tb_top.sv]
`timescale 1ns/1ps
module agd_sequencer_tb_top;
  import agd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwm = 1'b0;
  logic en = 1'b0;
  logic act = 1'b0;
  logic lsm = 1'b0;
  logic tm = 1'b0;
  logic step = 1'b0;
  logic [1:0] mode = 2'h2;
  logic [CODE_W-1:0] ipre = 6'h30;
  logic [CODE_W-1:0] ipdis = 6'h30;
  logic [CODE_W-1:0] max_c = 6'h28;
  logic [CODE_W-1:0] chg_c = 6'h1e;
  logic [CODE_W-1:0] dis_c = 6'h08;
  logic [CODE_W-1:0] fw_c = 6'h0a;
  logic [DLY_W-1:0] tgt = 8'h05;
  logic [DLY_W-1:0] pre_d = 8'h03;
  logic [DLY_W-1:0] ccp_d = 8'h08;
  logic sw_h, sw_l, hs_src, ls_src, flag, pg_src, cg_src;
  logic [CODE_W-1:0] hs_code, ls_code, pg_code;
  logic [DLY_W-1:0] m_on, m_off;
  logic cg_bad = 1'b0;
  int err_total = 0;
  int num_checks = 0;
  assign pg_src = lsm ? ls_src : hs_src;
  assign cg_src = lsm ? hs_src : ls_src;
  assign pg_code = lsm ? ls_code : hs_code;
  always #2.5 clk = ~clk;
  agd_sequencer DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .PWM_I(pwm), .SW_NODE_HIGH_I(sw_h),
    .SW_NODE_LOW_I(sw_l), .PWM_ENABLE_I(en), .ACTIVE_FREEWHEEL_SELECT_I(act),
    .LOW_SIDE_MAP_I(lsm), .GATE_CONTROL_MODE_I(mode), .TIME_MODULATION_ENABLE_I(tm),
    .ADAPT_STEP_SIZE_I(step), .INITIAL_PRECHARGE_CURRENT_I(ipre),
    .INITIAL_PREDISCHARGE_CURRENT_I(ipdis), .MAX_GATE_CURRENT_I(max_c),
    .CHARGE_CURRENT_CODE_I(chg_c), .DISCHARGE_CURRENT_CODE_I(dis_c),
    .FREEWHEEL_CURRENT_CODE_I(fw_c), .TARGET_TURN_ON_DELAY_I(tgt),
    .TARGET_TURN_OFF_DELAY_I(tgt), .PRECHARGE_DURATION_I(pre_d),
    .PREDISCHARGE_DURATION_I(pre_d), .CROSS_CURRENT_DURATION_I(ccp_d),
    .HS_SOURCE_O(hs_src), .HS_CURRENT_CODE_O(hs_code), .LS_SOURCE_O(ls_src),
    .LS_CURRENT_CODE_O(ls_code), .MEASURED_TURN_ON_O(m_on), .MEASURED_TURN_OFF_O(m_off),
    .DELAY_REGULATED_FLAG_O(flag));
  agd_bridge_model bridge (.clk_i(clk), .rst_i(rst), .hs_src_i(hs_src), .ls_src_i(ls_src),
    .ls_map_i(lsm), .sw_high_o(sw_h), .sw_low_o(sw_l));
  // passive free-wheeling must never source the complementary gate
  always @(negedge clk) begin
    if (!rst && en && !act && cg_src !== 1'b0) cg_bad <= 1'b1;
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic edge_wait(input logic v, output int n);
    pwm = v;
    n = 0;
    while (pg_src !== v && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic run(input int t, input logic [1:0] md, input logic a, input logic l,
      input logic [5:0] ip, input logic [5:0] ipd, input logic [5:0] on_c,
      input logic [5:0] off_c, input int cycles);
    int n;
    en = 1'b0;
    repeat (2) @(negedge clk);
    mode = md;
    act = a;
    lsm = l;
    ipre = ip;
    ipdis = ipd;
    step = l;
    repeat (50) @(negedge clk);
    en = 1'b1;
    repeat (2) @(negedge clk);
    check("flag after enable", 8'(flag), 8'h00);
    for (int c = 0; c < cycles; c++) begin
      edge_wait(1'b1, n);
      check("rise delay", 8'(a ? n > 70 : n < 6), 8'h01);
      check("on entry code", 8'(pg_code), 8'(on_c));
      n = 0;
      while (pg_code !== ip && n < 40) begin
        @(negedge clk);
        n++;
      end
      check("initial code in pre", 8'(n < 40), 8'(tm | (md == MODE_FIXED_PRE)));
      repeat (300) @(negedge clk);
      check("ramp end code", 8'(pg_code), 8'(max_c));
      check("comp gate on", 8'(cg_src), 8'h00);
      edge_wait(1'b0, n);
      check("fall delay", 8'(a ? n > 70 : n < 6), 8'h01);
      check("off entry code", 8'(pg_code), 8'(off_c));
      repeat (300) @(negedge clk);
      check("comp gate fw", 8'(cg_src), 8'(a));
      check("turn-on seen", 8'(m_on >= 8'h03), 8'h01);
      check("turn-off seen", 8'(m_off != 8'h00), 8'h01);
      if (md[1] == 1'b0) check("flag non-adaptive", 8'(flag), 8'h00);
    end
    $display("test %0d done", t);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    run(1, 2'h2, 1'b0, 1'b0, 6'h30, 6'h30, 6'h28, 6'h28, 1);
    run(2, 2'h3, 1'b1, 1'b0, 6'h30, 6'h30, 6'h28, 6'h28, 1);
    run(3, 2'h2, 1'b0, 1'b1, 6'h30, 6'h30, 6'h28, 6'h28, 1);
    run(4, 2'h0, 1'b0, 1'b0, 6'h12, 6'h14, 6'h1e, 6'h08, 1);
    run(5, 2'h1, 1'b1, 1'b1, 6'h12, 6'h14, 6'h12, 6'h14, 2);
    tm = 1'b1;
    run(6, 2'h2, 1'b0, 1'b0, 6'h30, 6'h30, 6'h28, 6'h28, 1);
    check("comp gate passive", 8'(cg_bad), 8'h00);
    close_out();
  end
  initial begin
    #60000;
    err_total++;
    close_out();
  end
endmodule
